//--- inc/scwr_defines.svh
`ifndef SCWR_DEFINES_SVH
`define SCWR_DEFINES_SVH

// ----------------------------------------------------------------
// Control word layout
// ----------------------------------------------------------------
`define SCWR_WORD_W     16          // Bits in one control word
`define SCWR_SHIFT_W    17          // Word plus the bit taken at latch
`define SCWR_ADDR_HI    3           // Select address field, top bit
`define SCWR_ADDR_LO    0           // Select address field, low bit
`define SCWR_DATA_HI    15          // Data field, top bit
`define SCWR_DATA_LO    4           // Data field, low bit
`define SCWR_CS_BIT     2           // Device-select bit
`define SCWR_ADDR_MASK  4'hB        // Address bits without device select
`define SCWR_MAIN_ADDR  4'h0        // Main source and output enable word

// ----------------------------------------------------------------
// Main source word fields
// ----------------------------------------------------------------
`define SCWR_SRC_HI     15          // Primary source code, top bit
`define SCWR_SRC_LO     10          // Primary source code, low bit
`define SCWR_REC_BIT    9           // Record output enable
`define SCWR_ZONE_BIT   6           // Zone output enable
`define SCWR_FIX_MASK   16'h01B8    // Bits 8,7,5,4,3 of the main word
`define SCWR_FIX_VALUE  16'h0020    // Bit 5 high, the rest low
`define SCWR_SRC_MAX    6'h22       // Highest permitted source code

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SCWR_SRC_RST    6'h00       // Source muted
`define SCWR_REC_RST    1'b0        // Record output off
`define SCWR_ZONE_RST   1'b0        // Zone output off

`endif

//--- inc/scwr_pkg.sv
`include "scwr_defines.svh"

package scwr_pkg;

    // ------------------------------------------------------------
    // Types shared by the receiver files
    // ------------------------------------------------------------
    typedef logic [`SCWR_WORD_W-1:0]             scwr_word_t;  // Word
    typedef logic [`SCWR_SRC_HI-`SCWR_SRC_LO:0]  scwr_src_t;   // Source
    typedef logic [`SCWR_ADDR_HI:`SCWR_ADDR_LO]  scwr_addr_t;  // Address
    typedef logic [`SCWR_DATA_HI-`SCWR_DATA_LO:0] scwr_data_t; // Data

    // Verdict on a word that has just crossed into the core domain
    typedef enum logic [1:0] {
        SCWR_FOREIGN,               // Meant for the other device
        SCWR_ROUTED,                // Valid, not the main word
        SCWR_MAIN_OK,               // Valid main word
        SCWR_MAIN_BAD               // Main word with bad fixed bits or prohibited source
    } scwr_verdict_e;

endpackage

//--- verilog/scwr_sync.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Two-stage level synchroniser, one chain per bit
// ----------------------------------------------------------------
module scwr_sync #(
    parameter int WIDTH = 2                 // Number of bits carried
) (
    input  wire logic             clk_i,    // Destination clock
    input  wire logic [WIDTH-1:0] async_i,  // Levels from another domain
    output logic      [WIDTH-1:0] sync_o    // Levels safe to use
);

    // No reset here: the chain only follows its input, and a reset
    // would fake a level change on release
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            logic stage1 = 1'b0;            // Read by stage2 only
            logic stage2 = 1'b0;            // Output stage

            // Two flops in series
            always_ff @(posedge clk_i) begin
                stage1 <= async_i[g];
                stage2 <= stage1;
            end

            assign sync_o[g] = stage2;
        end
    endgenerate

endmodule

//--- verilog/scwr_top.sv
`timescale 1ns/1ps
`include "scwr_defines.svh"

// What this block does
// - Sample data line on each serial clock rise
// - Detect latch on serial clock falling edge
// - Latch keeps only last sixteen captured bits
// - Low four bits address, upper twelve data
// - Main word: source, record, zone, fixed bits
// - Accept word only if select bit matches strap

module scwr_top (
    input  wire logic        ref_clk_i,        // Core clock, 125 MHz
    input  wire logic        rst_i,            // Sync reset, active high
    input  wire logic        serial_shift_clock_line_i, // Link clock
    input  wire logic        serial_data_latch_line_i,  // Data and latch
    input  wire logic        chip_select_strap_i,       // Strap pin
    output logic       [5:0] main_source_o,    // Primary source code
    output logic             rec_enable_o,     // Record output on
    output logic             zone_enable_o,    // Zone output on
    output logic             word_stb_o,       // Accepted word pulse
    output logic       [3:0] word_addr_o,      // Address of that word
    output logic      [11:0] word_data_o,      // Data of that word
    output logic             reject_stb_o      // Bad main word pulse
);

    // ------------------------------------------------------------
    // Link domain
    // ------------------------------------------------------------
    // The link clock stops between frames, so nothing here can be
    // reset by the core reset; power-up values give a known start.
    logic [`SCWR_SHIFT_W-1:0] shift_reg = '0;  // Bits as they arrive
    scwr_pkg::scwr_word_t     link_word = '0;  // Word held after latch
    logic                     link_tgl  = 1'b0; // Flips on each latch
    logic                     latch_seen;       // Latch at this fall

    // Shift one bit in at each rising edge, oldest at the top
    always_ff @(posedge serial_shift_clock_line_i) begin
        shift_reg <= {shift_reg[`SCWR_SHIFT_W-2:0],
                      serial_data_latch_line_i};
    end

    // Line high at the fall but low at the rise marks a latch;
    // a plain one bit is high at both edges and never matches
    assign latch_seen = serial_data_latch_line_i
                        && !shift_reg[0];

    // Hand the word over on the latching fall
    always_ff @(negedge serial_shift_clock_line_i) begin
        if (latch_seen) begin
            // Bit 0 is the rise of the latch pulse, not data
            link_word <= shift_reg[`SCWR_SHIFT_W-1:1];
            link_tgl  <= ~link_tgl;
        end
    end

    // ------------------------------------------------------------
    // Crossing into the core domain
    // ------------------------------------------------------------
    logic [1:0] sync_out;                 // Synchronised levels
    logic       tgl_sync;                 // Latch toggle, core side
    logic       strap_sync;               // Strap level, core side
    logic       tgl_seen;                 // Toggle already handled
    logic       new_word;                 // One-cycle arrival mark

    // Toggle and strap each pass two flops first
    scwr_sync #(
        .WIDTH (2)
    ) u_sync (
        .clk_i   (ref_clk_i),
        .async_i ({chip_select_strap_i, link_tgl}),
        .sync_o  (sync_out)
    );

    assign tgl_sync   = sync_out[0];
    assign strap_sync = sync_out[1];
    assign new_word   = tgl_sync ^ tgl_seen;

    // Remember the toggle; at reset take its present level so that
    // a word latched before reset is not replayed
    always_ff @(posedge ref_clk_i) begin
        tgl_seen <= tgl_sync;
    end

    // ------------------------------------------------------------
    // Word decode
    // ------------------------------------------------------------
    // The link word is safe to read here: it changes only at a latch,
    // and the next latch is at least seventeen link clocks away.
    scwr_pkg::scwr_addr_t    word_addr;   // Select address field
    scwr_pkg::scwr_data_t    word_data;   // Data field
    scwr_pkg::scwr_src_t     word_src;    // Primary source field
    scwr_pkg::scwr_verdict_e verdict;     // What to do with it
    logic                    cs_match;    // Select bit equals strap
    logic                    is_main;     // Main source word
    logic                    fixed_ok;    // Fixed bits as required
    logic                    src_ok;      // Source code permitted

    assign word_addr = link_word[`SCWR_ADDR_HI:`SCWR_ADDR_LO];
    assign word_data = link_word[`SCWR_DATA_HI:`SCWR_DATA_LO];
    assign word_src  = link_word[`SCWR_SRC_HI:`SCWR_SRC_LO];
    assign cs_match  = (link_word[`SCWR_CS_BIT] == strap_sync);
    assign is_main   = ((word_addr & `SCWR_ADDR_MASK)
                        == `SCWR_MAIN_ADDR);
    assign fixed_ok  = ((link_word & `SCWR_FIX_MASK)
                        == `SCWR_FIX_VALUE);
    assign src_ok    = (word_src <= `SCWR_SRC_MAX);

    // Foreign words are dropped before any other check
    assign verdict = !cs_match              ? scwr_pkg::SCWR_FOREIGN :
                     !is_main               ? scwr_pkg::SCWR_ROUTED  :
                     (fixed_ok && src_ok)   ? scwr_pkg::SCWR_MAIN_OK :
                                              scwr_pkg::SCWR_MAIN_BAD;

    // ------------------------------------------------------------
    // Routed word output
    // ------------------------------------------------------------
    // Every word for this device is shown with its address, so the
    // other address decoders can hang off this port.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            word_stb_o  <= 1'b0;
            word_addr_o <= '0;
            word_data_o <= '0;
        end else begin
            word_stb_o <= new_word && cs_match;
            if (new_word && cs_match) begin
                word_addr_o <= word_addr;
                word_data_o <= word_data;
            end
        end
    end

    // ------------------------------------------------------------
    // Main source and output enable register
    // ------------------------------------------------------------
    // A bad main word is refused whole rather than applied in part,
    // so a line glitch cannot pick a prohibited source.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            main_source_o <= `SCWR_SRC_RST;
            rec_enable_o  <= `SCWR_REC_RST;
            zone_enable_o <= `SCWR_ZONE_RST;
            reject_stb_o  <= 1'b0;
        end else begin
            reject_stb_o <= new_word
                && (verdict == scwr_pkg::SCWR_MAIN_BAD);
            if (new_word && (verdict == scwr_pkg::SCWR_MAIN_OK)) begin
                main_source_o <= word_src;
                rec_enable_o  <= link_word[`SCWR_REC_BIT];
                zone_enable_o <= link_word[`SCWR_ZONE_BIT];
            end
        end
    end

    // ------------------------------------------------------------
    // Checks in the link domain
    // ------------------------------------------------------------
    // Whole register moves up one place; depth 1 only, so the
    // first edges of a run already have a defined past value
    property p_capture;
        @(posedge serial_shift_clock_line_i) disable iff (rst_i)
        1 |=> shift_reg == {$past(shift_reg[`SCWR_SHIFT_W-2:0]),
                            $past(serial_data_latch_line_i)};
    endproperty
    a_capture: assert property (p_capture)
        else $error("Serial bit not shifted in at clock rise");

    property p_latch_fall;
        @(negedge serial_shift_clock_line_i) disable iff (rst_i)
        latch_seen |=> link_tgl != $past(link_tgl);
    endproperty
    a_latch_fall: assert property (p_latch_fall)
        else $error("Latch at clock fall not taken");

    property p_last16;
        @(negedge serial_shift_clock_line_i) disable iff (rst_i)
        latch_seen |=> link_word == $past(shift_reg[16:1]);
    endproperty
    a_last16: assert property (p_last16)
        else $error("Latched word is not the last sixteen bits");

    // ------------------------------------------------------------
    // Checks in the core domain
    // ------------------------------------------------------------
    // Two clock domains live here, so each property names its clock

    sequence s_arrive_own;
        new_word && cs_match;
    endsequence

    sequence s_arrive_main;
        new_word && cs_match && is_main;
    endsequence

    property p_foreign;
        @(posedge ref_clk_i) disable iff (rst_i)
        new_word && !cs_match |=> !word_stb_o && $stable(main_source_o)
                                  && $stable(rec_enable_o)
                                  && $stable(zone_enable_o);
    endproperty
    a_foreign: assert property (p_foreign)
        else $error("Word for the other device was taken");

    property p_route;
        @(posedge ref_clk_i) disable iff (rst_i)
        s_arrive_own |=> word_stb_o
            && word_addr_o == $past(link_word[3:0])
            && word_data_o == $past(link_word[15:4]);
    endproperty
    a_route: assert property (p_route)
        else $error("Accepted word not routed with its address");

    property p_main;
        @(posedge ref_clk_i) disable iff (rst_i)
        s_arrive_main ##0 (fixed_ok && src_ok) |=>
            main_source_o == $past(link_word[15:10])
            && rec_enable_o == $past(link_word[9])
            && zone_enable_o == $past(link_word[6]);
    endproperty
    a_main: assert property (p_main)
        else $error("Main word fields not applied");

    // Bad fixed bits and a prohibited source are both refused whole
    property p_bad_main;
        @(posedge ref_clk_i) disable iff (rst_i)
        s_arrive_main ##0 !(fixed_ok && src_ok) |=>
            reject_stb_o && $stable(main_source_o)
            && $stable(rec_enable_o) && !$changed(zone_enable_o);
    endproperty
    a_bad_main: assert property (p_bad_main)
        else $error("Main word with bad fixed bits was applied");

    property p_pulse;
        @(posedge ref_clk_i) disable iff (rst_i)
        word_stb_o |=> !word_stb_o [*2];
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("Word strobe longer than one cycle");

endmodule

//--- dv/scwr_host_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Host controller driving the two serial control lines
// ----------------------------------------------------------------
module scwr_host_model (
    output logic sclk_o,  // Serial shift clock, still between frames
    output logic sdata_o  // Serial data and latch line
);
    localparam time QTR = 16ns;  // Quarter of the 64 ns link period

    // Both lines rest low at power-up
    initial begin
        sclk_o  = 1'b0;
        sdata_o = 1'b0;
    end

    // One frame: n bits, top bit first, then a latch clock
    task automatic send(input logic [19:0] w, input int n);
        #5.3ns;  // Skew off the core clock grid
        for (int i = n - 1; i >= 0; i--) begin
            sdata_o = w[i];
            #QTR;
            sclk_o = 1'b1;
            #(2 * QTR);
            sclk_o = 1'b0;
            #QTR;  // Data moves only well clear of the fall
        end
        sdata_o = 1'b0;  // Low at the latch rise
        #QTR;
        sclk_o = 1'b1;
        #QTR;
        sdata_o = 1'b1;  // Raised while clock high
        #QTR;
        sclk_o = 1'b0;
        #QTR;
        sdata_o = 1'b0;
        #(80 * QTR);  // Idle gap well beyond 17 link clocks
    endtask
endmodule

//--- dv/scwr_tb_top.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Self-checking bench for the control word receiver
// ----------------------------------------------------------------
module scwr_tb_top;
    logic        ref_clk;     // Core clock
    logic        rst;         // Sync reset
    logic        sclk;        // Link clock from host
    logic        sdata;       // Data and latch line
    logic        strap;       // Device-select strap
    logic [5:0]  src;         // Primary source
    logic        rec;         // Record enable
    logic        zone;        // Zone enable
    logic        stb;         // Accepted word pulse
    logic [3:0]  addr;        // Accepted address
    logic [11:0] data;        // Accepted data
    logic        rej;         // Rejected main word pulse
    int          stb_cnt;     // Accepted word pulses seen
    int          rej_cnt;     // Reject pulses seen
    int          bad_count;       // Mismatches
    int          samples_checked; // Comparisons

    scwr_top i_scwr_top (
        .ref_clk_i                 (ref_clk),
        .rst_i                     (rst),
        .serial_shift_clock_line_i (sclk),
        .serial_data_latch_line_i  (sdata),
        .chip_select_strap_i       (strap),
        .main_source_o             (src),
        .rec_enable_o              (rec),
        .zone_enable_o             (zone),
        .word_stb_o                (stb),
        .word_addr_o               (addr),
        .word_data_o               (data),
        .reject_stb_o              (rej)
    );

    scwr_host_model i_scwr_host_model (
        .sclk_o  (sclk),
        .sdata_o (sdata)
    );

    // 125 MHz core clock
    initial begin
        ref_clk = 1'b0;
        forever begin
            #4ns ref_clk = ~ref_clk;
        end
    end

    // Count one-cycle pulses mid-cycle, clear of their launching edge
    always @(negedge ref_clk) begin
        if (stb === 1'b1) begin
            stb_cnt <= stb_cnt + 1;
        end
        if (rej === 1'b1) begin
            rej_cnt <= rej_cnt + 1;
        end
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: saw %h expected %h",
                     $time, seen, exp);
        end
    endtask

    // Send a frame, then compare pulse counts and the word outputs
    task automatic frame(input logic [19:0] w, input int n,
                         input int d_stb, input int d_rej,
                         input logic [15:0] exp_word);
        int s0;
        int r0;
        s0 = stb_cnt;
        r0 = rej_cnt;
        i_scwr_host_model.send(w, n);
        @(negedge ref_clk);
        check(16'(stb_cnt - s0), 16'(d_stb));
        check(16'(rej_cnt - r0), 16'(d_rej));
        check({data, addr}, exp_word);
    endtask

    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d",
                 samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1;
        strap = 1'b0;
        stb_cnt = 0;
        rej_cnt = 0;
        bad_count = 0;
        samples_checked = 0;
        repeat (16) @(negedge ref_clk);
        rst = 1'b0;
        @(negedge ref_clk);
        check({src, rec, zone, addr, data[3:0]}, 16'h0000);
        check({4'h0, data}, 16'h0000);
        $display("Test reset values done");
        // First word after power-up: source 05, record and zone on
        frame(20'h01660, 16, 1, 0, 16'h1660);
        check({8'h00, src, rec, zone}, 16'h0017);
        $display("Test main word done");
        // Select bit set while strap is low: ignored entirely
        frame(20'h01E64, 16, 0, 0, 16'h1660);
        check({8'h00, src, rec, zone}, 16'h0017);
        $display("Test foreign word done");
        strap = 1'b1;
        repeat (4) @(negedge ref_clk);
        // Highest legal source, outputs off
        frame(20'h08824, 16, 1, 0, 16'h8824);
        check({8'h00, src, rec, zone}, 16'h0088);
        // Bad fixed bit, then prohibited source 23: main state kept,
        // but the word is still ours and is shown on the word port
        frame(20'h08924, 16, 1, 1, 16'h8924);
        frame(20'h08C24, 16, 1, 1, 16'h8C24);
        check({8'h00, src, rec, zone}, 16'h0088);
        $display("Test main word limits done");
        // Twenty bits: only the last sixteen count
        frame(20'hF0664, 20, 1, 0, 16'h0664);
        check({8'h00, src, rec, zone}, 16'h0007);
        // Another address: passed out, main state untouched
        frame(20'h0ABC5, 16, 1, 0, 16'hABC5);
        check({8'h00, src, rec, zone}, 16'h0007);
        check({14'h0000, sclk, sdata}, 16'h0000);
        $display("Test framing and routing done");
        end_sim();
    end
endmodule
